//--- inc/fpreg_logic_regs.vh
// Function
// - Wide fills write all zeros or ones
// - Narrow fills write one 32-bit register
// - Fill with nonzero source fields is illegal
// - Fill while unit disabled raises disabled
// - Wide copy or invert either source
// - Narrow copy/invert, selector is wide plus one
// - First-source form needs zero second field
// - Second-source form needs zero first field
// - Copy/invert while disabled raises disabled
// - First-source copy leaves status register untouched
// - Wide two-source ops combine bit by bit
// - Narrow two-source ops, selector plus one
// - Or and nor selectors
// - And and nand selectors
// - Xor and xnor selectors
// - Or with one source inverted
// - And with one source inverted
// - Two-source op disabled: exception, no write
`ifndef FPREG_LOGIC_REGS_VH
`define FPREG_LOGIC_REGS_VH
`define OP_HI 31
`define OP_LO 30
`define OP_VAL 2'h2
`define DEST_HI 29
`define DEST_LO 25
`define GRP_HI 24
`define GRP_LO 19
`define GRP_VAL 6'h36
`define SRC1_HI 18
`define SRC1_LO 14
`define SEL_HI 13
`define SEL_LO 5
`define SRC2_HI 4
`define SRC2_LO 0
`define SEL_ZERO_W 9'h060
`define SEL_ONE_W 9'h07e
`define SEL_CPY1_W 9'h074
`define SEL_CPY2_W 9'h078
`define SEL_NOT1_W 9'h06a
`define SEL_NOT2_W 9'h066
`define SEL_OR_W 9'h07c
`define SEL_NOR_W 9'h062
`define SEL_AND_W 9'h070
`define SEL_NAND_W 9'h06e
`define SEL_XOR_W 9'h06c
`define SEL_XNOR_W 9'h072
`define SEL_ORN1_W 9'h07a
`define SEL_ORN2_W 9'h076
`define SEL_ANDN1_W 9'h068
`define SEL_ANDN2_W 9'h064
`define FN_ZERO 4'h0
`define FN_ONE 4'h1
`define FN_CPY1 4'h2
`define FN_CPY2 4'h3
`define FN_NOT1 4'h4
`define FN_NOT2 4'h5
`define FN_OR 4'h6
`define FN_NOR 4'h7
`define FN_AND 4'h8
`define FN_NAND 4'h9
`define FN_XOR 4'ha
`define FN_XNOR 4'hb
`define FN_ORN1 4'hc
`define FN_ORN2 4'hd
`define FN_ANDN1 4'he
`define FN_ANDN2 4'hf
`define CLS_NONE 2'h0
`define CLS_FILL 2'h1
`define CLS_SRC1 2'h2
`define CLS_SRC2 2'h3
`endif

//--- logic/selector_decode.v
`timescale 1ns/1ps
`include "fpreg_logic_regs.vh"
module selector_decode (
  input wire [31:0] instr, // Instruction word
  output reg hit, // Word belongs to this group
  output reg narrow, // 32-bit form
  output reg [3:0] func, // Operation code
  output reg [1:0] cls // Which source fields must be zero
);
  reg [8:0] wide_sel;
  always @*
  begin
    wide_sel = {instr[`SEL_HI:`SEL_LO+1], 1'b0};
    narrow = instr[`SEL_LO];
    func = `FN_ZERO;
    cls = `CLS_NONE;
    hit = (instr[`OP_HI:`OP_LO] == `OP_VAL) && (instr[`GRP_HI:`GRP_LO] == `GRP_VAL);
    // Narrow selector is the wide one with bit 0 set
    case (wide_sel)
      `SEL_ZERO_W:
      begin
        func = `FN_ZERO;
        cls = `CLS_FILL;
      end
      `SEL_ONE_W:
      begin
        func = `FN_ONE;
        cls = `CLS_FILL;
      end
      `SEL_CPY1_W:
      begin
        func = `FN_CPY1;
        cls = `CLS_SRC1;
      end
      `SEL_NOT1_W:
      begin
        func = `FN_NOT1;
        cls = `CLS_SRC1;
      end
      `SEL_CPY2_W:
      begin
        func = `FN_CPY2;
        cls = `CLS_SRC2;
      end
      `SEL_NOT2_W:
      begin
        func = `FN_NOT2;
        cls = `CLS_SRC2;
      end
      `SEL_OR_W: func = `FN_OR;
      `SEL_NOR_W: func = `FN_NOR;
      `SEL_AND_W: func = `FN_AND;
      `SEL_NAND_W: func = `FN_NAND;
      `SEL_XOR_W: func = `FN_XOR;
      `SEL_XNOR_W: func = `FN_XNOR;
      `SEL_ORN1_W: func = `FN_ORN1;
      `SEL_ORN2_W: func = `FN_ORN2;
      `SEL_ANDN1_W: func = `FN_ANDN1;
      `SEL_ANDN2_W: func = `FN_ANDN2;
      default: hit = 1'b0;
    endcase
  end
endmodule

//--- logic/bitwise_core.v
`timescale 1ns/1ps
`include "fpreg_logic_regs.vh"
module bitwise_core #(
  parameter WIDTH = 64
) (
  input wire [3:0] func, // Operation code
  input wire [WIDTH-1:0] a, // First source
  input wire [WIDTH-1:0] b, // Second source
  output reg [WIDTH-1:0] y // Result
);
  always @*
  begin
    case (func)
      `FN_ZERO: y = {WIDTH{1'b0}};
      `FN_ONE: y = {WIDTH{1'b1}};
      `FN_CPY1: y = a;
      `FN_CPY2: y = b;
      `FN_NOT1: y = ~a;
      `FN_NOT2: y = ~b;
      `FN_OR: y = a | b;
      `FN_NOR: y = ~(a | b);
      `FN_AND: y = a & b;
      `FN_NAND: y = ~(a & b);
      `FN_XOR: y = a ^ b;
      `FN_XNOR: y = ~(a ^ b);
      `FN_ORN1: y = ~a | b;
      `FN_ORN2: y = a | ~b;
      `FN_ANDN1: y = ~a & b;
      `FN_ANDN2: y = a & ~b;
      default: y = {WIDTH{1'b0}};
    endcase
  end
endmodule

//--- logic/fpreg_bitwise_logic_unit.v
`timescale 1ns/1ps
`include "fpreg_logic_regs.vh"
module fpreg_bitwise_logic_unit #(
  parameter WIDTH = 64,
  parameter HALF = 32
) (
  input wire clk, // Core clock
  input wire resetn, // Async reset, active low
  input wire issue_valid, // Instruction offered this cycle
  input wire [31:0] instr, // Instruction word
  input wire unit_enable_bit, // Unit enable in unit status register
  input wire processor_state_float_enable, // Processor-state enable
  input wire unit_present, // A floating-point unit exists
  output wire [4:0] first_source_field, // Read address, first source
  output wire [4:0] second_source_field, // Read address, second source
  output wire narrow_read, // Sources are 32-bit registers
  input wire [WIDTH-1:0] first_data, // First source data
  input wire [WIDTH-1:0] second_data, // Second source data
  output reg wr_en, // Destination write strobe
  output reg wr_narrow, // Write is to a 32-bit register
  output reg [4:0] wr_addr, // Destination register
  output reg [WIDTH-1:0] wr_data, // Write data
  output reg illegal_instruction, // Illegal-instruction exception pulse
  output reg unit_disabled_exception, // Unit-disabled exception pulse
  output wire float_status_write // Status register update request
);
  wire hit;
  wire narrow;
  wire [3:0] func;
  wire [1:0] cls;
  wire [WIDTH-1:0] wide_y;
  wire [HALF-1:0] half_y;
  wire s1_zero;
  wire s2_zero;
  reg bad_field;
  wire disabled;
  wire take;

  selector_decode u_dec (
    .instr(instr),
    .hit(hit),
    .narrow(narrow),
    .func(func),
    .cls(cls)
  );

  bitwise_core #(.WIDTH(WIDTH)) u_wide (
    .func(func),
    .a(first_data),
    .b(second_data),
    .y(wide_y)
  );

  // Narrow operands sit in the low half of the read data
  bitwise_core #(.WIDTH(HALF)) u_half (
    .func(func),
    .a(first_data[HALF-1:0]),
    .b(second_data[HALF-1:0]),
    .y(half_y)
  );

  assign first_source_field = instr[`SRC1_HI:`SRC1_LO];
  assign second_source_field = instr[`SRC2_HI:`SRC2_LO];
  assign narrow_read = narrow;
  // None of these operations touch the status register
  assign float_status_write = 1'b0;

  assign s1_zero = (first_source_field == 5'h00);
  assign s2_zero = (second_source_field == 5'h00);

  always @*
  begin
    case (cls)
      `CLS_FILL: bad_field = !s1_zero || !s2_zero;
      `CLS_SRC1: bad_field = !s2_zero;
      `CLS_SRC2: bad_field = !s1_zero;
      default: bad_field = 1'b0;
    endcase
  end

  assign disabled = !unit_enable_bit || !processor_state_float_enable || !unit_present;
  assign take = issue_valid && hit;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_en <= 1'b0;
      wr_narrow <= 1'b0;
      wr_addr <= 5'h00;
      wr_data <= {WIDTH{1'b0}};
      illegal_instruction <= 1'b0;
      unit_disabled_exception <= 1'b0;
    end
    else
    begin
      // Field check outranks the disabled check, so only one fires
      illegal_instruction <= take && bad_field;
      unit_disabled_exception <= take && !bad_field && disabled;
      wr_en <= take && !bad_field && !disabled;
      if (take && !bad_field && !disabled)
      begin
        wr_narrow <= narrow;
        wr_addr <= instr[`DEST_HI:`DEST_LO];
        wr_data <= narrow ? {{(WIDTH-HALF){1'b0}}, half_y} : wide_y;
      end
    end
  end
endmodule

//--- dv/fpreg_logic_checker_properties.sv
`timescale 1ns/1ps
module fpreg_logic_checker (
  input wire clk, // Clock
  input wire resetn, // Reset
  input wire issue_valid, // Offer
  input wire [31:0] instr, // Word
  input wire unit_enable_bit, // Enable
  input wire processor_state_float_enable, // Enable
  input wire unit_present, // Presence
  input wire wr_en, // Write
  input wire [4:0] wr_addr, // Destination
  input wire [63:0] wr_data, // Result
  input wire illegal_instruction, // Exception
  input wire unit_disabled_exception, // Exception
  input wire float_status_write // Status update
);
  wire grp = issue_valid && instr[31:30] == 2'h2 && instr[24:19] == 6'h36;
  wire en = unit_enable_bit && processor_state_float_enable && unit_present;
  wire clean = instr[18:14] == 5'h0 && instr[4:0] == 5'h0;
  wire [8:0] sel = instr[13:5];
  wire [2:0] ans = {wr_en, illegal_instruction, unit_disabled_exception};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_ONE_ANSWER: assert property ($onehot0(ans))
    else $error("two answers at once");
  AST_NO_STATUS: assert property (float_status_write == 1'b0)
    else $error("status update requested");
  AST_FOREIGN: assert property (issue_valid && !grp |=> ans == 3'h0)
    else $error("foreign word answered");
  AST_ZERO_FILL: assert property (grp && en && clean && sel == 9'h060 |=> wr_en && wr_data == 0)
    else $error("zero fill wrong");
  AST_ONE_FILL: assert property (grp && en && clean && sel == 9'h07e |=> wr_en && &wr_data)
    else $error("one fill wrong");
  AST_FILL_FIELDS: assert property (grp && !clean && sel[8:1] == 8'h30 |=> ans == 3'h2)
    else $error("fill fields not refused");
  AST_COPY1_FIELD: assert property (grp && sel == 9'h074 && instr[4:0] != 0 |=> ans == 3'h2)
    else $error("copy field not refused");
  AST_DISABLED: assert property (grp && !en && sel == 9'h070 |=> ans == 3'h1)
    else $error("disabled unit wrote");
  AST_WRITE_ADDR: assert property (wr_en |-> wr_addr == $past(instr[29:25]))
    else $error("destination wrong");
endmodule

//--- dv/fpreg_file_model.sv
`timescale 1ns/1ps
module fpreg_file_model (
  input wire [4:0] addr_a, // First read address
  input wire [4:0] addr_b, // Second read address
  output wire [63:0] data_a, // First read data
  output wire [63:0] data_b // Second read data
);
  // A distinct pattern per register so a wrong read address shows
  assign data_a = {{12{addr_a}}, 4'h6};
  assign data_b = {{12{addr_b}}, 4'h6};
endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
  localparam [143:0] WIDE = {9'h060, 9'h07e, 9'h074, 9'h078, 9'h06a, 9'h066, 9'h07c, 9'h062,
    9'h070, 9'h06e, 9'h06c, 9'h072, 9'h07a, 9'h076, 9'h068, 9'h064};
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg vld = 1'b0;
  reg [31:0] instr = 32'h0;
  reg [2:0] ena = 3'h7;
  reg [5:0] grp = 6'h36;
  reg [8:0] s;
  reg z1, z2;
  wire [4:0] fa, fb, wa;
  wire [63:0] da, db, wd;
  wire nr, we, wn, ill, dis, fsw;
  integer num_errors = 0;
  integer total_checks = 0;
  integer i;
  initial forever #10 clk = ~clk;
  fpreg_bitwise_logic_unit fpreg_bitwise_logic_unit_i (.clk(clk), .resetn(resetn),
    .issue_valid(vld), .instr(instr), .unit_enable_bit(ena[0]),
    .processor_state_float_enable(ena[1]), .unit_present(ena[2]),
    .first_source_field(fa), .second_source_field(fb), .narrow_read(nr),
    .first_data(da), .second_data(db), .wr_en(we), .wr_narrow(wn), .wr_addr(wa),
    .wr_data(wd), .illegal_instruction(ill), .unit_disabled_exception(dis),
    .float_status_write(fsw));
  fpreg_file_model fpreg_file_model_i (.addr_a(fa), .addr_b(fb), .data_a(da), .data_b(db));
  function [63:0] calc(input [8:0] c, input [63:0] a, input [63:0] b);
    begin
      case (c & 9'h1fe)
        9'h060: calc = 64'h0;
        9'h07e: calc = ~64'h0;
        9'h074: calc = a;
        9'h078: calc = b;
        9'h06a: calc = ~a;
        9'h066: calc = ~b;
        9'h07c: calc = a | b;
        9'h062: calc = ~(a | b);
        9'h070: calc = a & b;
        9'h06e: calc = ~(a & b);
        9'h06c: calc = a ^ b;
        9'h072: calc = ~(a ^ b);
        9'h07a: calc = ~a | b;
        9'h076: calc = a | ~b;
        9'h068: calc = ~a & b;
        default: calc = a & ~b;
      endcase
      // Narrow results sit in the low half with the upper half cleared
      if (c[0])
        calc = calc & 64'h00000000ffffffff;
    end
  endfunction
  // Kind: 0 write, 1 illegal, 2 disabled, 3 nothing; valid stays up for back-to-back issue
  task op(input [8:0] c, input [4:0] r1, input [4:0] r2, input [1:0] kind);
    reg ok;
    begin
      vld = 1'b1;
      instr = {2'h2, r1 ^ 5'h15, grp, r1, c, r2};
      @(negedge clk);
      total_checks = total_checks + 1;
      case (kind)
        2'h0: ok = {we, ill, dis} === 3'h4 && wa === (r1 ^ 5'h15) && wn === c[0]
          && wd === calc(c, {{12{r1}}, 4'h6}, {{12{r2}}, 4'h6});
        2'h1: ok = {we, ill, dis} === 3'h2;
        2'h2: ok = {we, ill, dis} === 3'h1;
        default: ok = {we, ill, dis} === 3'h0;
      endcase
      if (nr !== c[0] || fsw !== 1'b0)
        ok = 1'b0;
      if (!ok)
      begin
        num_errors = num_errors + 1;
        $display("ERROR %0t: selector %h kind %0d", $time, c, kind);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    for (i = 0; i < 32; i = i + 1)
    begin
      s = WIDE[(15 - i / 2) * 9 +: 9] + i % 2;
      z1 = (s & 9'h1fe) inside {9'h060, 9'h07e, 9'h078, 9'h066};
      z2 = (s & 9'h1fe) inside {9'h060, 9'h07e, 9'h074, 9'h06a};
      op(s, z1 ? 5'h0 : i + 1, z2 ? 5'h0 : i + 3, 2'h0);
      if (z1 || z2)
        op(s, z1 ? 5'h4 : i + 1, z2 ? 5'h2 : i + 3, 2'h1);
      ena = 3'h7 ^ (3'h1 << (i % 3));
      op(s, z1 ? 5'h0 : i + 1, z2 ? 5'h0 : i + 3, 2'h2);
      if (z1 || z2)
        op(s, 5'h7, 5'h7, 2'h1);
      ena = 3'h7;
    end
    $display("selector test done");
    grp = 6'h34;
    op(9'h070, 5'h1, 5'h2, 2'h3);
    grp = 6'h36;
    op(9'h050, 5'h1, 5'h2, 2'h3);
    vld = 1'b0;
    @(negedge clk);
    $display("decode test done");
    print_verdict;
  end
endmodule
bind fpreg_bitwise_logic_unit fpreg_logic_checker chk_i (.clk(clk), .resetn(resetn),
  .issue_valid(issue_valid), .instr(instr), .unit_enable_bit(unit_enable_bit),
  .processor_state_float_enable(processor_state_float_enable), .unit_present(unit_present),
  .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .illegal_instruction(illegal_instruction),
  .unit_disabled_exception(unit_disabled_exception), .float_status_write(float_status_write));
